// [cpu_bus_model.sv]
/*
  Processor-side model of the register port: one-cycle write and read strobes.
  Assumes the block answers a read in the cycle after the strobe, never stalling.
*/
module cpu_bus_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Idle lines show the inverse of the last value, so stale data never looks valid
  task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : read_reg

  task automatic cmd_three(input logic [15:0] a, input logic en, input logic set, input logic poll,
                           input logic rb_en, input logic rb_sel);
    write_reg(a, {1'b0, en, set, 2'b01, poll, rb_en, rb_sel});
  endtask : cmd_three

  task automatic poll_read(input logic [15:0] a, input logic [15:0] status_addr, output logic [7:0] d);
    cmd_three(a, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    read_reg(status_addr, d);
  endtask : poll_read
endmodule : cpu_bus_model

// [pic_cmd_decode.sv]
/*
  Combinational decoder for a byte written to a shared command address.
  Assumes the byte is only meaningful while the write strobe is high.
*/
module pic_cmd_decode (
  // Written byte
  input wire logic [7:0] wdata,
  // Decoded target
  output pic_query_pkg::cmd_target_t target,
  output logic bad_word
);

  always_comb begin
    if (wdata[pic_query_pkg::BIT_RSEL_HI]) begin
      target = pic_query_pkg::SEL_INIT_ONE;
    end else if (wdata[pic_query_pkg::BIT_RSEL_LO]) begin
      target = pic_query_pkg::SEL_WORD_THREE;
    end else begin
      target = pic_query_pkg::SEL_WORD_TWO;
    end
    // Only word three carries a must-be-zero top bit
    bad_word = wdata[pic_query_pkg::BIT_RESERVED] && !wdata[pic_query_pkg::BIT_RSEL_HI]
               && wdata[pic_query_pkg::BIT_RSEL_LO];
  end

endmodule : pic_cmd_decode

// [pic_master_operation_word_three_poll_control.sv]
/*
  Command-word-three path and poll readback for a master and a slave
  interrupt controller. Each instance keeps special mask mode, a poll arm
  flag and a readback choice; requests come in as pulses on req_in.
  Assumes same-clock request pulses and a one-cycle strobe register port.
*/
// What this block does
// - enable low keeps special mask; enable high, setting low leaves it.
// - register-select bits steer a command write to word one, two or three.
// - poll bit set arms a poll; the next read of the command or poll address returns poll status.
// - readback enable and select pick request or in-service register.
// - poll status top bit is set while any unmasked request not blocked by in-service waits.
// - poll status low bits give highest waiting level when pending.
// - poll status bits six to three always read as zero.
module pic_master_operation_word_three_poll_control (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Request pulses from sources
  input wire logic [7:0] master_req_in,
  input wire logic [7:0] slave_req_in,
  // Mask and in-service levels from the mask word and end-of-interrupt logic
  input wire logic [7:0] master_mask,
  input wire logic [7:0] slave_mask,
  input wire logic [7:0] master_eoi_clear,
  input wire logic [7:0] slave_eoi_clear,
  // Mode and interrupt
  output logic master_special_mask,
  output logic slave_special_mask,
  output logic irq
);

  pic_query_pkg::ctl_state_t ctl [2];
  logic [7:0] request_register [2];
  logic [7:0] in_service_register [2];
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [2:0] next_evt;

  logic is_cmd [2];
  logic is_poll_rd [2];
  logic [7:0] eligible [2];
  logic found [2];
  logic [2:0] level [2];
  logic [7:0] in_mask [2];
  logic [7:0] in_eoi [2];
  logic [7:0] in_req [2];
  pic_query_pkg::cmd_target_t target;
  logic bad_word;

  pic_cmd_decode u_decode (
    .wdata(wdata),
    .target(target),
    .bad_word(bad_word)
  );

  assign in_mask[0] = master_mask;
  assign in_mask[1] = slave_mask;
  assign in_eoi[0] = master_eoi_clear;
  assign in_eoi[1] = slave_eoi_clear;
  assign in_req[0] = master_req_in;
  assign in_req[1] = slave_req_in;
  assign is_cmd[0] = (addr == pic_query_pkg::MASTER_CMD_ADDR);
  assign is_cmd[1] = (addr == pic_query_pkg::SLAVE_CMD_ADDR);

  // Highest set in-service level blocks itself and everything below it
  function automatic logic [7:0] below_mask(input logic [7:0] isr_v);
    logic [7:0] m;
    logic seen;
    m = 8'h00;
    seen = 1'b0;
    for (int i = 0; i < pic_query_pkg::NUM_LEVELS; i++) begin
      if (isr_v[i]) begin
        seen = 1'b1;
      end
      m[i] = seen;
    end
    return m;
  endfunction : below_mask

  function automatic logic [7:0] onehot(input logic [2:0] l);
    return 8'h01 << l;
  endfunction : onehot

  // Poll status may sit at the master data address; the slave's is printed
  assign is_poll_rd[0] = rd && (is_cmd[0] || addr == pic_query_pkg::MASTER_DATA_ADDR)
                         && ctl[0].poll_armed;
  assign is_poll_rd[1] = rd && (is_cmd[1] || addr == pic_query_pkg::SLAVE_POLL_ADDR)
                         && ctl[1].poll_armed;

  for (genvar g = 0; g < 2; g++) begin : g_ctl
    // In special mask mode a masked in-service level no longer blocks lower ones
    always_comb begin
      if (ctl[g].special_mask_setting) begin
        eligible[g] = request_register[g] & ~in_mask[g] & ~in_service_register[g];
      end else begin
        eligible[g] = request_register[g] & ~in_mask[g] & ~below_mask(in_service_register[g]);
      end
    end

    pic_priority_pick u_pick (
      .eligible(eligible[g]),
      .found(found[g]),
      .level(level[g])
    );

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        ctl[g].special_mask_setting <= 1'b0;
        ctl[g].poll_armed <= 1'b0;
        ctl[g].readback <= pic_query_pkg::READ_REQUEST;
      end else if (wr && is_cmd[g] && target == pic_query_pkg::SEL_WORD_THREE) begin
        if (wdata[pic_query_pkg::BIT_SMASK_EN]) begin
          ctl[g].special_mask_setting <= wdata[pic_query_pkg::BIT_SMASK_SET];
        end
        ctl[g].poll_armed <= wdata[pic_query_pkg::BIT_POLL];
        if (wdata[pic_query_pkg::BIT_RB_EN]) begin
          ctl[g].readback <= wdata[pic_query_pkg::BIT_RB_SEL] ? pic_query_pkg::READ_IN_SERVICE
                                                              : pic_query_pkg::READ_REQUEST;
        end
      end else if (wr && is_cmd[g] && target == pic_query_pkg::SEL_INIT_ONE) begin
        // Initialisation restarts the readback and drops special mask
        ctl[g].special_mask_setting <= 1'b0;
        ctl[g].poll_armed <= 1'b0;
        ctl[g].readback <= pic_query_pkg::READ_REQUEST;
      end else if (rd && (is_cmd[g] || is_poll_rd[g])) begin
        // A poll is good for one read only
        ctl[g].poll_armed <= 1'b0;
      end
    end

    // New requests win over the acknowledge clear in the same cycle
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        request_register[g] <= pic_query_pkg::ZERO_BYTE;
      end else if (is_poll_rd[g] && found[g]) begin
        request_register[g] <= (request_register[g] & ~onehot(level[g])) | in_req[g];
      end else begin
        request_register[g] <= request_register[g] | in_req[g];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        in_service_register[g] <= pic_query_pkg::ZERO_BYTE;
      end else if (is_poll_rd[g] && found[g]) begin
        in_service_register[g] <= (in_service_register[g] & ~in_eoi[g]) | onehot(level[g]);
      end else begin
        in_service_register[g] <= in_service_register[g] & ~in_eoi[g];
      end
    end
  end

  // Test hook: software-set requests, helpful for poll-only systems
  // are folded into req_in by the surrounding logic, not here.

  function automatic logic [7:0] poll_byte(input logic f, input logic [2:0] l);
    logic [7:0] b;
    b = pic_query_pkg::ZERO_BYTE;
    b[pic_query_pkg::BIT_PENDING] = f;
    if (f) begin
      b[2:0] = l;
    end
    return b;
  endfunction : poll_byte

  function automatic logic [7:0] rb_byte(input pic_query_pkg::readback_t s, input logic [7:0] r,
                                         input logic [7:0] i);
    return (s == pic_query_pkg::READ_IN_SERVICE) ? i : r;
  endfunction : rb_byte

  // Read data: one cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= pic_query_pkg::ZERO_BYTE;
    end else if (!rd) begin
      rdata <= pic_query_pkg::ZERO_BYTE;
    end else if (is_poll_rd[0]) begin
      rdata <= poll_byte(found[0], level[0]);
    end else if (is_poll_rd[1]) begin
      rdata <= poll_byte(found[1], level[1]);
    end else begin
      unique case (addr)
        pic_query_pkg::MASTER_CMD_ADDR: rdata <= rb_byte(ctl[0].readback, request_register[0], in_service_register[0]);
        pic_query_pkg::SLAVE_CMD_ADDR: rdata <= rb_byte(ctl[1].readback, request_register[1], in_service_register[1]);
        pic_query_pkg::IRQ_STATUS_ADDR: rdata <= {5'h00, evt_status};
        pic_query_pkg::IRQ_MASK_ADDR: rdata <= {5'h00, evt_mask};
        pic_query_pkg::MODE_STATUS_ADDR: rdata <= {4'h0, ctl[1].poll_armed, ctl[0].poll_armed,
                                                   ctl[1].special_mask_setting,
                                                   ctl[0].special_mask_setting};
        default: rdata <= pic_query_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Event capture; a status read clears, but a same-cycle event survives
  always_comb begin
    next_evt = pic_query_pkg::ZERO_EVT;
    next_evt[pic_query_pkg::EVT_POLL_HIT] = (is_poll_rd[0] && found[0]) || (is_poll_rd[1] && found[1]);
    next_evt[pic_query_pkg::EVT_POLL_EMPTY] = (is_poll_rd[0] && !found[0]) || (is_poll_rd[1] && !found[1]);
    next_evt[pic_query_pkg::EVT_BAD_WORD] = wr && (is_cmd[0] || is_cmd[1]) && bad_word;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_status <= pic_query_pkg::ZERO_EVT;
    end else if (rd && addr == pic_query_pkg::IRQ_STATUS_ADDR) begin
      evt_status <= next_evt;
    end else begin
      evt_status <= evt_status | next_evt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evt_mask <= pic_query_pkg::ZERO_EVT;
    end else if (wr && addr == pic_query_pkg::IRQ_MASK_ADDR) begin
      evt_mask <= wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
      master_special_mask <= 1'b0;
      slave_special_mask <= 1'b0;
    end else begin
      // A set mask bit silences its event, the same sense as the request masks
      irq <= |(next_evt & ~evt_mask) || |(evt_status & ~evt_mask & ~{3{rd && addr == pic_query_pkg::IRQ_STATUS_ADDR}});
      master_special_mask <= ctl[0].special_mask_setting;
      slave_special_mask <= ctl[1].special_mask_setting;
    end
  end

  // Named steps of the command and poll flows; g picks master (0) or slave (1)
  sequence s_poll_cmd(int g);
    wr && is_cmd[g] && target == pic_query_pkg::SEL_WORD_THREE && wdata[pic_query_pkg::BIT_POLL];
  endsequence

  sequence s_smm_enter(int g);
    wr && is_cmd[g] && target == pic_query_pkg::SEL_WORD_THREE && wdata[pic_query_pkg::BIT_SMASK_EN]
      && wdata[pic_query_pkg::BIT_SMASK_SET];
  endsequence

  sequence s_smm_leave(int g);
    wr && is_cmd[g] && target == pic_query_pkg::SEL_WORD_THREE && wdata[pic_query_pkg::BIT_SMASK_EN]
      && !wdata[pic_query_pkg::BIT_SMASK_SET];
  endsequence

  sequence s_poll_hit(int g);
    is_poll_rd[g] && found[g];
  endsequence

  sequence s_poll_miss(int g);
    is_poll_rd[g] && !found[g];
  endsequence

  // Poll flow: arm, answer once, acknowledge
  AST_POLL_ARMS: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_cmd(1) |=> ctl[1].poll_armed) else $error("slave poll command did not arm");

  AST_POLL_ARMS_MASTER: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_cmd(0) |=> ctl[0].poll_armed) else $error("master poll command did not arm");

  AST_POLL_ONE_SHOT: assert property (@(posedge ref_clk) disable iff (rst)
    is_poll_rd[0] |=> !ctl[0].poll_armed) else $error("poll still armed after its read");

  AST_POLL_PENDING: assert property (@(posedge ref_clk) disable iff (rst)
    is_poll_rd[1] && !is_poll_rd[0]
    |=> rdata[pic_query_pkg::BIT_PENDING] == $past(found[1])) else $error("slave pending bit wrong");

  AST_POLL_PENDING_MASTER: assert property (@(posedge ref_clk) disable iff (rst)
    is_poll_rd[0] |=> rdata[pic_query_pkg::BIT_PENDING] == $past(found[0])) else $error("master pending bit wrong");

  AST_POLL_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_hit(1) |=> rdata[2:0] == $past(level[1])) else $error("slave level wrong");

  AST_POLL_LEVEL_MASTER: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_hit(0) |=> rdata[2:0] == $past(level[0])) else $error("master level wrong");

  AST_POLL_EMPTY: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_miss(1) |=> rdata == pic_query_pkg::ZERO_BYTE) else $error("empty poll byte not zero");

  AST_POLL_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
    is_poll_rd[0] |=> rdata[6:3] == 4'h0) else $error("master reserved bits set");

  AST_POLL_RSVD_SLAVE: assert property (@(posedge ref_clk) disable iff (rst)
    is_poll_rd[1] |=> rdata[6:3] == 4'h0) else $error("slave reserved bits set");

  AST_ACK: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_hit(0) |=> in_service_register[0][$past(level[0])]) else $error("master poll ack did not set in-service");

  AST_ACK_SLAVE: assert property (@(posedge ref_clk) disable iff (rst)
    s_poll_hit(1) |=> in_service_register[1][$past(level[1])]) else $error("slave poll ack did not set in-service");

  // A fresh request on the same level may legally refill the bit
  AST_ACK_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
    is_poll_rd[1] && found[1] && !in_req[1][level[1]]
    |=> !request_register[1][$past(level[1])]) else $error("poll ack did not clear request");

  // Special mask mode and register select
  AST_SMM_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    wr && is_cmd[0] && target == pic_query_pkg::SEL_WORD_THREE && !wdata[pic_query_pkg::BIT_SMASK_EN]
    |=> $stable(ctl[0].special_mask_setting)) else $error("special mask changed");

  AST_SMM_LEAVE: assert property (@(posedge ref_clk) disable iff (rst)
    s_smm_leave(0) |=> ##1 !master_special_mask) else $error("special mask not left");

  AST_SMM_ENTER: assert property (@(posedge ref_clk) disable iff (rst)
    s_smm_enter(0) |=> ##1 master_special_mask) else $error("special mask not entered");

  AST_SMM_ENTER_SLAVE: assert property (@(posedge ref_clk) disable iff (rst)
    s_smm_enter(1) |=> ##1 slave_special_mask) else $error("slave special mask not entered");

  AST_WORD_TWO_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
    wr && is_cmd[1] && target == pic_query_pkg::SEL_WORD_TWO && !rd
    |=> $stable(ctl[1])) else $error("word two hit");

  AST_INIT_DROPS: assert property (@(posedge ref_clk) disable iff (rst)
    wr && is_cmd[1] && target == pic_query_pkg::SEL_INIT_ONE
    |=> !ctl[1].special_mask_setting && !ctl[1].poll_armed) else $error("word one kept mode");

  // Readback source
  AST_READBACK_ISR: assert property (@(posedge ref_clk) disable iff (rst)
    rd && is_cmd[0] && !ctl[0].poll_armed && ctl[0].readback == pic_query_pkg::READ_IN_SERVICE
    |=> rdata == $past(in_service_register[0])) else $error("in-service readback wrong");

  AST_READBACK_IRR: assert property (@(posedge ref_clk) disable iff (rst)
    rd && is_cmd[0] && !ctl[0].poll_armed && ctl[0].readback == pic_query_pkg::READ_REQUEST
    |=> rdata == $past(request_register[0])) else $error("request readback wrong");

  // Events and interrupt
  AST_BAD_WORD_EVENT: assert property (@(posedge ref_clk) disable iff (rst)
    wr && is_cmd[0] && target == pic_query_pkg::SEL_WORD_THREE && wdata[pic_query_pkg::BIT_RESERVED]
    |=> evt_status[pic_query_pkg::EVT_BAD_WORD]) else $error("bad word event lost");

  AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> irq == |(evt_status & ~$past(evt_mask))) else $error("irq does not follow unmasked status");

endmodule : pic_master_operation_word_three_poll_control

// [pic_priority_pick.sv]
/*
  Fixed-priority picker: level 0 highest. Finds the highest pending level.
  Assumes the caller has already applied masking and in-service blocking.
*/
module pic_priority_pick (
  // Candidate levels
  input wire logic [7:0] eligible,
  // Result
  output logic found,
  output logic [2:0] level
);

  always_comb begin
    found = 1'b0;
    level = 3'h0;
    for (int i = pic_query_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        level = 3'(i);
      end
    end
  end

endmodule : pic_priority_pick

// [pic_query_pkg.sv]
/*
  Shared constants and types for the command-word-three and poll-status block
  of a cascaded interrupt controller pair (master and slave).
  Assumes a plain register port with one-cycle strobes and 8-bit data.
*/
package pic_query_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_LEVELS = 8;
  localparam int LEVEL_W = 3;

  // Register addresses, printed offsets are byte addresses
  localparam logic [15:0] MASTER_CMD_ADDR = 16'hf020;
  localparam logic [15:0] MASTER_DATA_ADDR = 16'hf021;
  localparam logic [15:0] SLAVE_CMD_ADDR = 16'hf0a0;
  localparam logic [15:0] SLAVE_POLL_ADDR = 16'hf0a1;
  localparam logic [15:0] MASTER_REQ_SET_ADDR = 16'hf0c0;
  localparam logic [15:0] SLAVE_REQ_SET_ADDR = 16'hf0c1;
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'hf0c2;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'hf0c3;
  localparam logic [15:0] MODE_STATUS_ADDR = 16'hf0c4;

  // Command word field positions
  localparam int BIT_RESERVED = 7;
  localparam int BIT_SMASK_EN = 6;
  localparam int BIT_SMASK_SET = 5;
  localparam int BIT_RSEL_HI = 4;
  localparam int BIT_RSEL_LO = 3;
  localparam int BIT_POLL = 2;
  localparam int BIT_RB_EN = 1;
  localparam int BIT_RB_SEL = 0;

  // Poll status byte layout
  localparam int BIT_PENDING = 7;

  // Interrupt status bits
  localparam int EVT_POLL_HIT = 0;
  localparam int EVT_POLL_EMPTY = 1;
  localparam int EVT_BAD_WORD = 2;
  localparam int EVT_W = 3;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] ZERO_EVT = 3'h0;

  typedef enum logic [1:0] {
    SEL_INIT_ONE,
    SEL_WORD_TWO,
    SEL_WORD_THREE
  } cmd_target_t;

  typedef enum logic {
    READ_REQUEST,
    READ_IN_SERVICE
  } readback_t;

  // Settings of one controller instance
  typedef struct packed {
    logic special_mask_setting;
    logic poll_armed;
    readback_t readback;
  } ctl_state_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : pic_query_pkg

// [tb_top.sv]
/*
  Self-checking bench for the command-word-three and poll-status block.
  Assumes the processor model drives the register port and this module the request lines.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] master_req_in = 8'h00;
  logic [7:0] slave_req_in = 8'h00;
  logic [7:0] master_mask = 8'h00;
  logic [7:0] slave_mask = 8'h00;
  logic [7:0] master_eoi_clear = 8'h00;
  logic [7:0] slave_eoi_clear = 8'h00;
  logic master_special_mask;
  logic slave_special_mask;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] d;

  pic_master_operation_word_three_poll_control dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .master_req_in(master_req_in), .slave_req_in(slave_req_in), .master_mask(master_mask),
    .slave_mask(slave_mask), .master_eoi_clear(master_eoi_clear), .slave_eoi_clear(slave_eoi_clear),
    .master_special_mask(master_special_mask), .slave_special_mask(slave_special_mask), .irq(irq));
  cpu_bus_model cpu (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // A hang costs a mismatch rather than a silent stall
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic pulse(input logic slave, input logic eoi, input logic [7:0] v);
    @(posedge ref_clk);
    if (eoi) begin
      if (slave) slave_eoi_clear <= v;
      else master_eoi_clear <= v;
    end else begin
      if (slave) slave_req_in <= v;
      else master_req_in <= v;
    end
    @(posedge ref_clk);
    {slave_eoi_clear, master_eoi_clear, slave_req_in, master_req_in} <= 32'h0000_0000;
  endtask : pulse

  task automatic test_reset;
    cpu.read_reg(pic_query_pkg::MODE_STATUS_ADDR, d);
    check("mode status", 8'h00, d);
    check("outputs", 8'h00, {5'h00, irq, slave_special_mask, master_special_mask});
    $display("test reset done");
  endtask : test_reset

  task automatic test_special_mask;
    logic [7:0] seq [7] = '{8'h68, 8'h28, 8'h08, 8'h00, 8'h48, 8'h68, 8'h10};
    logic [6:0] exp = 7'b0101111;
    for (int i = 0; i < 2; i++) begin
      for (int s = 0; s < 7; s++) begin
        cpu.write_reg(i ? pic_query_pkg::SLAVE_CMD_ADDR : pic_query_pkg::MASTER_CMD_ADDR, seq[s]);
        @(posedge ref_clk);
        #1;
        check("special mask", {7'h00, exp[s]}, {7'h00, i ? slave_special_mask : master_special_mask});
      end
    end
    $display("test special mask done");
  endtask : test_special_mask

  task automatic test_master_poll;
    pulse(1'b0, 1'b0, 8'h08);
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    cpu.read_reg(pic_query_pkg::MASTER_CMD_ADDR, d);
    check("request readback", 8'h08, d);
    cpu.poll_read(pic_query_pkg::MASTER_CMD_ADDR, pic_query_pkg::MASTER_DATA_ADDR, d);
    check("master poll", 8'h83, d);
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cpu.read_reg(pic_query_pkg::MASTER_CMD_ADDR, d);
    check("in-service readback", 8'h08, d);
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    cpu.read_reg(pic_query_pkg::MASTER_CMD_ADDR, d);
    check("request after ack", 8'h00, d);
    pulse(1'b0, 1'b1, 8'h08);
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cpu.read_reg(pic_query_pkg::MASTER_CMD_ADDR, d);
    check("in-service after clear", 8'h00, d);
    $display("test master poll done");
  endtask : test_master_poll

  task automatic test_slave_poll;
    pulse(1'b1, 1'b0, 8'h24);
    cpu.poll_read(pic_query_pkg::SLAVE_CMD_ADDR, pic_query_pkg::SLAVE_CMD_ADDR, d);
    check("slave poll first", 8'h82, d);
    pulse(1'b1, 1'b1, 8'h04);
    cpu.poll_read(pic_query_pkg::SLAVE_CMD_ADDR, pic_query_pkg::SLAVE_POLL_ADDR, d);
    check("slave poll second", 8'h85, d);
    pulse(1'b1, 1'b1, 8'h20);
    cpu.poll_read(pic_query_pkg::SLAVE_CMD_ADDR, pic_query_pkg::SLAVE_POLL_ADDR, d);
    check("slave poll empty", 8'h00, d);
    $display("test slave poll done");
  endtask : test_slave_poll

  task automatic test_nesting;
    pulse(1'b0, 1'b0, 8'h08);
    cpu.poll_read(pic_query_pkg::MASTER_CMD_ADDR, pic_query_pkg::MASTER_DATA_ADDR, d);
    master_mask <= 8'h08;
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    pulse(1'b0, 1'b0, 8'h20);
    cpu.poll_read(pic_query_pkg::MASTER_CMD_ADDR, pic_query_pkg::MASTER_DATA_ADDR, d);
    check("poll past masked level", 8'h85, d);
    pulse(1'b0, 1'b1, 8'h28);
    master_mask <= 8'h00;
    cpu.cmd_three(pic_query_pkg::MASTER_CMD_ADDR, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test nesting done");
  endtask : test_nesting

  // Mask bits set silence the matching event
  task automatic test_irq;
    #1;
    check("irq raised", 8'h01, {7'h00, irq});
    cpu.read_reg(pic_query_pkg::IRQ_STATUS_ADDR, d);
    check("event status", 8'h03, d);
    cpu.write_reg(pic_query_pkg::MASTER_CMD_ADDR, 8'h88);
    repeat (2) @(posedge ref_clk);
    #1;
    check("irq bad word", 8'h01, {7'h00, irq});
    cpu.write_reg(pic_query_pkg::IRQ_MASK_ADDR, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    check("irq masked", 8'h00, {7'h00, irq});
    cpu.read_reg(pic_query_pkg::IRQ_MASK_ADDR, d);
    check("event mask", 8'h04, d);
    cpu.read_reg(pic_query_pkg::IRQ_STATUS_ADDR, d);
    check("bad word status", 8'h04, d);
    cpu.read_reg(pic_query_pkg::MASTER_REQ_SET_ADDR, d);
    check("reserved read", 8'h00, d);
    $display("test irq done");
  endtask : test_irq

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_special_mask();
    test_master_poll();
    test_slave_poll();
    test_nesting();
    test_irq();
    complete_run();
  end
endmodule : tb_top
